// File: rtl/fsw_state_word.sv
// State-word logic of the integrated floating-point unit with its APB register slave
// Behaviour
// - Extension-type flag reads one always and ignores writes.
// - Unmasked exceptions use vector 16 when error mode set, else external path.
// - Reset clears numeric-error-mode; software sets it for internal reporting.
// - Monitor and task-switched both set: waiting instructions raise vector 7.
// - Initialize or reset clears all four condition codes.
// - Incomplete partial remainder clears condition codes zero, one, three.
// - Condition code two flags out-of-range operand of partial tangent.
// - Stack fault sets stack-fault, and invalid unless on initialize; code one shows overflow.
// - Infinity-control bit is read/write but arithmetic is always affine.
// - Loaded tags 00, 01, 10 mean non-empty; 11 means empty.
// - Operand class comes from register contents, never stored tag.
// - Saving regenerates tags of all non-empty registers from contents.
// - Unsupported formats like pseudo-zero or unnormal get the special tag.
// - Signaling and quiet NaNs are told apart; only quiet ones produced.
// - Signaling NaN raises invalid; compare and stores also on quiet NaN.
// - Pseudo and unnormal operands raise invalid and are never produced.
module fsw_state_word (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Integer unit instruction side
  input  wire fsw_pkg::fsw_instr_t   instr,
  input  wire fsw_pkg::fsw_data_wr_t data_wr,
  output fsw_pkg::fsw_exc_t          exc,
  output logic                      ext_error,
  output logic      [15:0]          tags_out,
  output logic                      tags_out_valid,
  // Interrupt
  output logic                      irq
);

  fsw_pkg::fsw_state_t s;
  fsw_pkg::fsw_state_t next_s;
  logic [fsw_pkg::NUM_EVENTS-1:0] ev;
  logic [79:0]                    op;
  logic                           op_invalid;
  logic                           stk_fault;
  logic                           apb_access;
  logic                           apb_write;
  logic                           apb_bad_addr;
  logic [31:0]                    rd_value;

  function automatic logic is_unsupported(input logic [79:0] v);
    // Integer bit clear with a non-zero exponent: pseudo forms and unnormals
    is_unsupported = (v[78:64] != 15'h0000) && !v[63];
  endfunction : is_unsupported

  function automatic logic is_nan(input logic [79:0] v);
    is_nan = (v[78:64] == fsw_pkg::EXP_MAX) && v[63] && (v[62:0] != 63'h0);
  endfunction : is_nan

  function automatic logic is_signaling_nan(input logic [79:0] v);
    is_signaling_nan = is_nan(v) && !v[62];
  endfunction : is_signaling_nan

  function automatic logic [1:0] classify(input logic [79:0] v);
    if (v[78:64] == 15'h0000 && v[63:0] == 64'h0) begin
      classify = fsw_pkg::TAG_ZERO;
    end else if (v[78:64] == 15'h0000 || v[78:64] == fsw_pkg::EXP_MAX || !v[63]) begin
      classify = fsw_pkg::TAG_SPECIAL;
    end else begin
      classify = fsw_pkg::TAG_VALID;
    end
  endfunction : classify

  function automatic logic [15:0] build_tags(input logic [7:0][79:0] regs, input logic [7:0] empty);
    logic [15:0] t;
    t = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      t[2*i +: 2] = empty[i] ? fsw_pkg::TAG_EMPTY : classify(regs[i]);
    end
    build_tags = t;
  endfunction : build_tags

  // Result values are cleaned so no signaling or unsupported value is ever stored
  function automatic logic [79:0] sanitize(input logic [79:0] v);
    if (is_unsupported(v)) begin
      sanitize = fsw_pkg::QUIET_DEFAULT;
    end else if (is_signaling_nan(v)) begin
      sanitize = {v[79:63], 1'b1, v[61:0]};
    end else begin
      sanitize = v;
    end
  endfunction : sanitize

  assign apb_access   = psel && penable && !s.pready;
  assign apb_write    = psel && penable && s.pready && pwrite && !s.pslverr;
  assign apb_bad_addr = (paddr[1:0] != 2'h0) || (paddr > fsw_pkg::OFS_IRQ_MASK);

  always_comb begin
    rd_value = 32'h0000_0000;
    if (paddr == fsw_pkg::OFS_CTRL_ZERO) begin
      rd_value = s.ctrl_zero;
    end else if (paddr == fsw_pkg::OFS_STATUS) begin
      rd_value = {16'h0000, s.status};
    end else if (paddr == fsw_pkg::OFS_CONTROL) begin
      rd_value = {16'h0000, s.control};
    end else if (paddr == fsw_pkg::OFS_TAGS) begin
      rd_value = {16'h0000, build_tags(s.regs, s.empty)};
    end else if (paddr == fsw_pkg::OFS_IRQ_STAT) begin
      rd_value = {29'h0000_0000, s.irq_stat};
    end else if (paddr == fsw_pkg::OFS_IRQ_MASK) begin
      rd_value = {29'h0000_0000, s.irq_mask};
    end
  end

  always_comb begin
    next_s                = s;
    next_s.exc            = '0;
    next_s.tags_out_valid = 1'b0;
    ev                    = '0;
    op                    = s.regs[instr.src_reg];
    op_invalid            = 1'b0;
    stk_fault             = 1'b0;

    // APB: one wait state; write data lands on the edge that sees pready, read data is registered on the edge that raises it
    if (apb_access) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = apb_bad_addr;
      next_s.prdata  = apb_bad_addr ? 32'h0000_0000 : rd_value;
    end else begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
    end
    if (apb_write) begin
      if (paddr == fsw_pkg::OFS_CTRL_ZERO) begin
        next_s.ctrl_zero = pwdata;
      end else if (paddr == fsw_pkg::OFS_CONTROL) begin
        next_s.control = pwdata[15:0];
      end else if (paddr == fsw_pkg::OFS_IRQ_MASK) begin
        next_s.irq_mask = pwdata[fsw_pkg::NUM_EVENTS-1:0];
      end
    end
    next_s.ctrl_zero[fsw_pkg::BIT_EXTENSION_TYPE] = 1'b1;

    if (instr.valid) begin
      if (instr.waiting && s.ctrl_zero[fsw_pkg::BIT_MONITOR_COPROC]
          && s.ctrl_zero[fsw_pkg::BIT_TASK_SWITCHED]) begin
        // The instruction is refused; its state effects are suppressed
        next_s.exc.valid  = 1'b1;
        next_s.exc.vector = fsw_pkg::VEC_DEV_NOT_AVAIL;
        ev[fsw_pkg::EV_DEV_AVAIL] = 1'b1;
      end else begin
        case (instr.kind)
          fsw_pkg::FSW_INIT: begin
            next_s.status  = 16'h0000;
            next_s.control = fsw_pkg::CONTROL_RESET;
            next_s.empty   = 8'hff;
          end
          fsw_pkg::FSW_PREM: begin
            next_s.status[fsw_pkg::BIT_COND_TWO] = instr.prem_incomplete;
            if (instr.prem_incomplete) begin
              next_s.status[fsw_pkg::BIT_COND_ZERO]  = 1'b0;
              next_s.status[fsw_pkg::BIT_COND_ONE]   = 1'b0;
              next_s.status[fsw_pkg::BIT_COND_THREE] = 1'b0;
            end
          end
          fsw_pkg::FSW_PTAN: begin
            next_s.status[fsw_pkg::BIT_COND_TWO] = instr.ptan_out_of_range;
          end
          fsw_pkg::FSW_ENV_LOAD: begin
            for (int i = 0; i < 8; i++) begin
              next_s.empty[i] = (instr.tags_in[2*i +: 2] == fsw_pkg::TAG_EMPTY);
            end
          end
          fsw_pkg::FSW_ENV_SAVE: begin
            next_s.tags_out       = build_tags(s.regs, s.empty);
            next_s.tags_out_valid = 1'b1;
          end
          fsw_pkg::FSW_WAIT: begin
          end
          default: begin
            // Operand is judged by its bits; the stored tag plays no part
            if (!s.empty[instr.src_reg]) begin
              if (is_signaling_nan(op)) begin
                op_invalid = 1'b1;
              end else if (is_nan(op) && (instr.kind == fsw_pkg::FSW_COMPARE
                           || instr.kind == fsw_pkg::FSW_INT_STORE
                           || instr.kind == fsw_pkg::FSW_BCD_STORE)) begin
                op_invalid = 1'b1;
              end else if (is_unsupported(op)) begin
                op_invalid = 1'b1;
              end
            end
          end
        endcase

        if (instr.stack_event != fsw_pkg::FSW_STK_NONE) begin
          stk_fault = 1'b1;
          next_s.status[fsw_pkg::BIT_STACK_FAULT] = 1'b1;
          next_s.status[fsw_pkg::BIT_COND_ONE] = (instr.stack_event == fsw_pkg::FSW_STK_OVER);
          ev[fsw_pkg::EV_STACK] = 1'b1;
        end

        if ((op_invalid || stk_fault) && instr.kind != fsw_pkg::FSW_INIT) begin
          next_s.status[fsw_pkg::BIT_INVALID_OP] = 1'b1;
          ev[fsw_pkg::EV_INVALID] = 1'b1;
          if (!s.control[fsw_pkg::BIT_INVALID_MASK]) begin
            next_s.status[fsw_pkg::BIT_ERR_SUMMARY] = 1'b1;
            if (s.ctrl_zero[fsw_pkg::BIT_NUMERIC_ERROR]) begin
              next_s.exc.valid  = 1'b1;
              next_s.exc.vector = fsw_pkg::VEC_FP_ERROR;
            end
          end
        end
      end
    end

    // Datapath results; infinity control is never consulted, closure stays affine
    if (data_wr.we) begin
      next_s.regs[data_wr.idx]  = sanitize(data_wr.value);
      next_s.empty[data_wr.idx] = 1'b0;
    end

    // External error path follows the summary bit while internal reporting is off
    next_s.ext_error = next_s.status[fsw_pkg::BIT_ERR_SUMMARY]
                       && !next_s.ctrl_zero[fsw_pkg::BIT_NUMERIC_ERROR];

    // Set wins over a same-cycle write-one-to-clear
    next_s.irq_stat = s.irq_stat | ev;
    if (apb_write && paddr == fsw_pkg::OFS_IRQ_STAT) begin
      next_s.irq_stat = (s.irq_stat & ~pwdata[fsw_pkg::NUM_EVENTS-1:0]) | ev;
    end
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s           <= '0;
      s.ctrl_zero <= 32'h0000_0010;
      s.status    <= 16'h0000;
      s.control   <= fsw_pkg::CONTROL_RESET;
      s.empty     <= 8'hff;
    end else begin
      s <= next_s;
    end
  end

  assign prdata         = s.prdata;
  assign pready         = s.pready;
  assign pslverr        = s.pslverr;
  assign exc            = s.exc;
  assign ext_error      = s.ext_error;
  assign tags_out       = s.tags_out;
  assign tags_out_valid = s.tags_out_valid;
  assign irq            = s.irq;

endmodule : fsw_state_word

// File: rtl/fsw_pkg.sv
// Package with constants and carrier types for the floating-point state-word logic
package fsw_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_CTRL_ZERO = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_CONTROL   = 8'h08;
  localparam logic [7:0] OFS_TAGS      = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;

  // Control register zero fields
  localparam int BIT_MONITOR_COPROC = 1;
  localparam int BIT_TASK_SWITCHED  = 3;
  localparam int BIT_EXTENSION_TYPE = 4;
  localparam int BIT_NUMERIC_ERROR  = 5;

  // Status word fields
  localparam int BIT_INVALID_OP  = 0;
  localparam int BIT_STACK_FAULT = 6;
  localparam int BIT_ERR_SUMMARY = 7;
  localparam int BIT_COND_ZERO   = 8;
  localparam int BIT_COND_ONE    = 9;
  localparam int BIT_COND_TWO    = 10;
  localparam int BIT_COND_THREE  = 14;

  // Control word fields and reset value
  localparam int          BIT_INVALID_MASK = 0;
  localparam int          BIT_INFINITY_CTL = 12;
  localparam logic [15:0] CONTROL_RESET    = 16'h0040;

  // Exception vectors
  localparam logic [7:0] VEC_DEV_NOT_AVAIL = 8'h07;
  localparam logic [7:0] VEC_FP_ERROR      = 8'h10;

  // Tag encodings
  localparam logic [1:0] TAG_VALID   = 2'h0;
  localparam logic [1:0] TAG_ZERO    = 2'h1;
  localparam logic [1:0] TAG_SPECIAL = 2'h2;
  localparam logic [1:0] TAG_EMPTY   = 2'h3;

  // Interrupt event bits
  localparam int EV_INVALID   = 0;
  localparam int EV_STACK     = 1;
  localparam int EV_DEV_AVAIL = 2;
  localparam int NUM_EVENTS   = 3;

  // Extended real layout and the default quiet value
  localparam logic [14:0] EXP_MAX       = 15'h7fff;
  localparam logic [79:0] QUIET_DEFAULT = 80'hffff_c000_0000_0000_0000;

  typedef enum logic [3:0] {
    FSW_ARITH, FSW_COMPARE, FSW_INT_STORE, FSW_BCD_STORE, FSW_INIT,
    FSW_PREM, FSW_PTAN, FSW_ENV_LOAD, FSW_ENV_SAVE, FSW_WAIT
  } fsw_kind_t;

  typedef enum logic [1:0] {FSW_STK_NONE, FSW_STK_OVER, FSW_STK_UNDER} fsw_stack_t;

  typedef struct packed {
    logic       valid;
    fsw_kind_t  kind;
    logic       waiting;
    logic [2:0] src_reg;
    fsw_stack_t stack_event;
    logic       prem_incomplete;
    logic       ptan_out_of_range;
    logic [15:0] tags_in;
  } fsw_instr_t;

  typedef struct packed {
    logic        we;
    logic [2:0]  idx;
    logic [79:0] value;
  } fsw_data_wr_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
  } fsw_exc_t;

  typedef struct packed {
    logic [7:0][79:0]      regs;
    logic [7:0]            empty;
    logic [31:0]           ctrl_zero;
    logic [15:0]           status;
    logic [15:0]           control;
    logic [NUM_EVENTS-1:0] irq_stat;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic                  irq;
    logic                  ext_error;
    fsw_exc_t              exc;
    logic [15:0]           tags_out;
    logic                  tags_out_valid;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } fsw_state_t;

endpackage : fsw_pkg

// File: bench/fsw_assertions.sv
// Port checker for the floating-point state-word block
module fsw_assertions (
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  // Integer unit side
  input wire fsw_pkg::fsw_instr_t   instr,
  input wire fsw_pkg::fsw_data_wr_t data_wr,
  input wire fsw_pkg::fsw_exc_t     exc,
  input wire logic                  ext_error,
  input wire logic [15:0]           tags_out,
  input wire logic                  tags_out_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic monitor_coproc_flag;
  logic task_switched_flag;
  logic numeric_error_mode;
  logic trap_due;
  logic ld;
  logic sv;

  // Mirror of the flags, updated at the completing edge of a write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {numeric_error_mode, task_switched_flag, monitor_coproc_flag} <= 3'h0;
    end else if (psel && penable && pready && pwrite && paddr == fsw_pkg::OFS_CTRL_ZERO) begin
      numeric_error_mode  <= pwdata[fsw_pkg::BIT_NUMERIC_ERROR];
      task_switched_flag  <= pwdata[fsw_pkg::BIT_TASK_SWITCHED];
      monitor_coproc_flag <= pwdata[fsw_pkg::BIT_MONITOR_COPROC];
    end
  end

  function automatic logic [7:0] empt(input logic [15:0] t);
    for (int i = 0; i < 8; i++) begin
      empt[i] = &t[2*i+:2];
    end
  endfunction : empt

  assign ld = instr.valid && instr.kind == fsw_pkg::FSW_ENV_LOAD && !instr.waiting && !data_wr.we;
  assign sv = instr.valid && instr.kind == fsw_pkg::FSW_ENV_SAVE && !instr.waiting;
  assign trap_due = instr.valid && instr.waiting && monitor_coproc_flag && task_switched_flag;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_ext_type_one;
    pready && !pwrite && paddr == fsw_pkg::OFS_CTRL_ZERO |-> prdata[fsw_pkg::BIT_EXTENSION_TYPE];
  endproperty
  a_ext_type_one: assert property (p_ext_type_one) else $error("extension flag read as zero");
  property p_nm_vec;
    trap_due |=> exc.valid && exc.vector == fsw_pkg::VEC_DEV_NOT_AVAIL;
  endproperty
  a_nm_vec: assert property (p_nm_vec) else $error("no vector 7 on waiting instruction");
  property p_nm_sup;
    trap_due |=> !tags_out_valid;
  endproperty
  a_nm_sup: assert property (p_nm_sup) else $error("trapped instruction not suppressed");
  property p_fp_vec;
    exc.valid && exc.vector == fsw_pkg::VEC_FP_ERROR |-> $past(numeric_error_mode);
  endproperty
  a_fp_vec: assert property (p_fp_vec) else $error("vector 16 with error mode clear");
  property p_ext;
    ext_error |-> !(numeric_error_mode && $past(numeric_error_mode) && $past(numeric_error_mode, 2));
  endproperty
  a_ext: assert property (p_ext) else $error("external error with error mode set");
  property p_save;
    sv |=> tags_out_valid;
  endproperty
  a_save: assert property (p_save) else $error("save gave no tag word");
  property p_cause;
    tags_out_valid |-> $past(instr.valid && instr.kind == fsw_pkg::FSW_ENV_SAVE);
  endproperty
  a_cause: assert property (p_cause) else $error("tag word without save");
  property p_load;
    ld ##1 (sv && !data_wr.we) |=> empt(tags_out) == empt($past(instr.tags_in, 2));
  endproperty
  a_load: assert property (p_load) else $error("loaded empty marks lost");
endmodule : fsw_assertions

// File: bench/fsw_iu_model.sv
// Integer-unit stand-in that issues instructions and writes data registers
module fsw_iu_model (
  // Clock
  input  wire logic                 ref_clk,
  // Block side
  output fsw_pkg::fsw_instr_t       instr,
  output fsw_pkg::fsw_data_wr_t     data_wr,
  input  wire fsw_pkg::fsw_exc_t    exc,
  input  wire logic                 tags_out_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    instr = '0;
    data_wr = '0;
  end

  task automatic wr_reg(input logic [2:0] r, input logic [79:0] v);
    @(posedge ref_clk);
    data_wr <= {1'b1, r, v};
    @(posedge ref_clk);
    data_wr <= '0;
  endtask : wr_reg

  // Two instructions back to back; b may be idle
  task automatic issue(input fsw_pkg::fsw_instr_t a, input fsw_pkg::fsw_instr_t b,
                       output fsw_pkg::fsw_exc_t ea, output fsw_pkg::fsw_exc_t eb, output logic tv);
    @(posedge ref_clk);
    instr <= a;
    @(posedge ref_clk);
    instr <= b;
    @(posedge ref_clk);
    instr <= '0;
    ea = exc;
    tv = tags_out_valid;
    @(posedge ref_clk);
    eb = exc;
    tv = tv | tags_out_valid;
  endtask : issue
endmodule : fsw_iu_model

// File: bench/tb.sv
// Self-checking bench for the floating-point state-word block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk = 0;
  logic                  rst_n = 0;
  logic                  psel = 0;
  logic                  penable = 0;
  logic                  pwrite = 0;
  logic [7:0]            paddr = '0;
  logic [31:0]           pwdata = '0;
  logic [31:0]           prdata;
  logic [31:0]           rdat;
  logic                  pready;
  logic                  pslverr;
  logic                  rerr;
  logic                  ext_error;
  logic                  tags_out_valid;
  logic                  irq;
  logic                  tv;
  logic [15:0]           tags_out;
  fsw_pkg::fsw_instr_t   instr;
  fsw_pkg::fsw_data_wr_t data_wr;
  fsw_pkg::fsw_exc_t     exc;
  fsw_pkg::fsw_exc_t     ea;
  fsw_pkg::fsw_exc_t     eb;
  int                    failures = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;

  fsw_state_word dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr),
    .data_wr(data_wr), .exc(exc), .ext_error(ext_error), .tags_out(tags_out),
    .tags_out_valid(tags_out_valid), .irq(irq));
  fsw_iu_model iu (.ref_clk(ref_clk), .instr(instr), .data_wr(data_wr), .exc(exc),
    .tags_out_valid(tags_out_valid));

  initial forever #4 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register read", e, rdat);
  endtask : rd

  function automatic fsw_pkg::fsw_instr_t op(fsw_pkg::fsw_kind_t k, logic [2:0] r = 0,
      fsw_pkg::fsw_stack_t s = fsw_pkg::FSW_STK_NONE, logic [1:0] f = 0, logic [15:0] t = 0, logic w = 0);
    op = {1'b1, k, w, r, s, f, t};
  endfunction : op

  task automatic t_regs();
    rd(fsw_pkg::OFS_CTRL_ZERO, 32'h10);
    rd(fsw_pkg::OFS_CONTROL, 32'h40);
    rd(fsw_pkg::OFS_TAGS, 32'hffff);
    apb(1'b0, 8'h18, 32'h0);
    chk("pslverr", 1, rerr);
    apb(1'b1, fsw_pkg::OFS_CTRL_ZERO, 32'h0);
    rd(fsw_pkg::OFS_CTRL_ZERO, 32'h10);
    apb(1'b1, fsw_pkg::OFS_CTRL_ZERO, 32'h22);
    rd(fsw_pkg::OFS_CTRL_ZERO, 32'h32);
    apb(1'b1, fsw_pkg::OFS_CONTROL, 32'h1040);
    rd(fsw_pkg::OFS_CONTROL, 32'h1040);
    $display("register test done");
  endtask : t_regs

  task automatic t_stack();
    iu.issue(op(fsw_pkg::FSW_ARITH, 0, fsw_pkg::FSW_STK_OVER), '0, ea, eb, tv);
    chk("exception", 9'h110, ea);
    rd(fsw_pkg::OFS_STATUS, 32'h02c1);
    chk("irq masked", 0, irq);
    apb(1'b1, fsw_pkg::OFS_IRQ_MASK, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk("irq", 1, irq);
    apb(1'b1, fsw_pkg::OFS_IRQ_STAT, 32'h3);
    rd(fsw_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq cleared", 0, irq);
    iu.issue(op(fsw_pkg::FSW_ARITH, 0, fsw_pkg::FSW_STK_UNDER), '0, ea, eb, tv);
    rd(fsw_pkg::OFS_STATUS, 32'h00c1);
    iu.issue(op(fsw_pkg::FSW_ARITH, 0, fsw_pkg::FSW_STK_OVER), op(fsw_pkg::FSW_PREM, 0,
      fsw_pkg::FSW_STK_NONE, 2'b10), ea, eb, tv);
    rd(fsw_pkg::OFS_STATUS, 32'h04c1);
    for (int i = 0; i < 2; i++) begin
      iu.issue(op(fsw_pkg::FSW_PTAN, 0, fsw_pkg::FSW_STK_NONE, i[1:0]), '0, ea, eb, tv);
      rd(fsw_pkg::OFS_STATUS, i ? 32'h04c1 : 32'h00c1);
    end
    iu.issue(op(fsw_pkg::FSW_INIT), '0, ea, eb, tv);
    rd(fsw_pkg::OFS_STATUS, 32'h0);
    rd(fsw_pkg::OFS_CONTROL, 32'h40);
    $display("status test done");
  endtask : t_stack

  task automatic t_tags();
    fsw_pkg::fsw_kind_t k[5] = '{fsw_pkg::FSW_ARITH, fsw_pkg::FSW_COMPARE, fsw_pkg::FSW_INT_STORE,
      fsw_pkg::FSW_BCD_STORE, fsw_pkg::FSW_ARITH};
    iu.wr_reg(3'h0, 80'h0);
    iu.wr_reg(3'h1, 80'h3fff_8000_0000_0000_0000);
    iu.wr_reg(3'h2, 80'h3fff_4000_0000_0000_0000);
    iu.issue(op(fsw_pkg::FSW_ENV_SAVE), '0, ea, eb, tv);
    chk("tag word", 32'h1ffe1, {tv, tags_out});
    iu.issue(op(fsw_pkg::FSW_ENV_LOAD, 0, fsw_pkg::FSW_STK_NONE, 0, 16'hfff8), op(fsw_pkg::FSW_ENV_SAVE),
      ea, eb, tv);
    chk("tag word", 32'hfff1, tags_out);
    iu.wr_reg(3'h3, 80'h7fff_c000_0000_0000_0000);
    iu.wr_reg(3'h4, 80'h7fff_a000_0000_0000_0000);
    // The signaling value is quieted on entry, so arithmetic on it stays silent
    for (int i = 0; i < 5; i++) begin
      iu.issue(op(k[i], i == 4 ? 3'h4 : 3'h3), '0, ea, eb, tv);
      chk("exc valid", i inside {1, 2, 3}, ea.valid);
      if (i inside {1, 2, 3}) chk("exc vector", 8'h10, ea.vector);
    end
    apb(1'b1, fsw_pkg::OFS_CTRL_ZERO, 32'h2);
    iu.issue(op(fsw_pkg::FSW_COMPARE, 3), '0, ea, eb, tv);
    chk("exc valid", 0, ea.valid);
    chk("ext error", 1, ext_error);
    $display("tag and operand test done");
  endtask : t_tags

  task automatic t_trap();
    apb(1'b1, fsw_pkg::OFS_CTRL_ZERO, 32'h2a);
    iu.issue(op(fsw_pkg::FSW_WAIT, 0, fsw_pkg::FSW_STK_NONE, 0, 0, 1),
      op(fsw_pkg::FSW_ENV_SAVE, 0, fsw_pkg::FSW_STK_NONE, 0, 0, 1), ea, eb, tv);
    chk("trap", 32'h20f07, {tv, eb, ea});
    rd(fsw_pkg::OFS_IRQ_STAT, 32'h7);
    apb(1'b1, fsw_pkg::OFS_CTRL_ZERO, 32'h22);
    iu.issue(op(fsw_pkg::FSW_WAIT, 0, fsw_pkg::FSW_STK_NONE, 0, 0, 1), '0, ea, eb, tv);
    chk("no trap", 0, ea.valid);
    $display("trap test done");
  endtask : t_trap

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_stack();
    t_tags();
    t_trap();
    print_verdict();
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end
endmodule : tb

bind fsw_state_word fsw_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .instr(instr),
  .data_wr(data_wr), .exc(exc), .ext_error(ext_error), .tags_out(tags_out), .tags_out_valid(tags_out_valid));
